// File: hdl/fwes_host.sv
// host sequencer driving an asynchronous boot-block flash over its parallel pins
`timescale 1ns/10ps
`default_nettype none
`include "fwes_defines.svh"
module fwes_host (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire fwes_pkg::fwes_req_s REQ,
    output logic DONE,
    output logic REFUSED,
    output logic [7:0] STATUS,
    output logic [15:0] RDATA,
    output logic VPP_LOCK,
    output var fwes_pkg::fwes_bus_s BUS,
    input wire logic [15:0] DQ_IN
);
    import fwes_pkg::*;

    // protocol state
    fwes_state_e state_reg, state_next;
    fwes_req_s req_reg, req_next;
    logic [1:0] cnt_reg, cnt_next;
    logic phase_reg, phase_next, suspend_ok;
    logic lock_reg, lock_next;
    logic done_reg, done_next;
    logic refused_reg, refused_next;
    logic [7:0] status_reg, status_next;
    logic [15:0] rdata_reg, rdata_next;
    logic array_mode_reg, array_mode_next;
    fwes_bus_s bus_reg, bus_next;
    logic [15:0] dq_s1_reg, dq_s2_reg;

    // two-stage sampling of the asynchronous data pins
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            dq_s1_reg <= 16'h0000;
            dq_s2_reg <= 16'h0000;
        end else begin
            dq_s1_reg <= DQ_IN;
            dq_s2_reg <= dq_s1_reg;
        end
    end

    // first command code of each operation
    function automatic logic [7:0] first_code(input logic [2:0] op);
        case (op)
            `FWES_OP_PROGRAM: first_code = `FWES_CMD_PROG_SETUP;
            `FWES_OP_ERASE: first_code = `FWES_CMD_ERASE_SETUP;
            `FWES_OP_SUSPEND: first_code = `FWES_CMD_SUSPEND;
            `FWES_OP_RESUME: first_code = `FWES_CMD_CONFIRM;
            `FWES_OP_CLEAR: first_code = `FWES_CMD_CLEAR_STATUS;
            default: first_code = `FWES_CMD_READ_ARRAY;
        endcase
    endfunction

    // one write pulse: low for the pulse time, then high for the recovery time
    function automatic fwes_bus_s wr_bus(input fwes_addr_t a, input logic [15:0] d,
                                         input logic low);
        fwes_bus_s b;
        b.ce_n = 1'b0;
        b.we_n = ~low;
        b.oe_n = 1'b1;
        b.dq_oe = 1'b1;
        b.addr = a;
        b.dq_out = d;
        return b;
    endfunction

    // a suspend request is also taken while a polled erase still reports busy
    assign suspend_ok = state_reg == FWES_CHECK && req_reg.op == `FWES_OP_ERASE
                        && !dq_s2_reg[`FWES_BIT_READY] && REQ.op == `FWES_OP_SUSPEND;
    assign REQ_READY = (state_reg == FWES_IDLE) || suspend_ok;

    // next-state logic
    always_comb begin
        state_next = state_reg;
        req_next = req_reg;
        cnt_next = cnt_reg;
        phase_next = phase_reg;
        lock_next = lock_reg;
        done_next = 1'b0;
        refused_next = 1'b0;
        status_next = status_reg;
        rdata_next = rdata_reg;
        array_mode_next = array_mode_reg;
        bus_next = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, dq_oe: 1'b0,
                     addr: bus_reg.addr, dq_out: bus_reg.dq_out};
        case (state_reg)
            FWES_IDLE: begin
                if (REQ_VALID) begin
                    req_next = REQ;
                    cnt_next = 2'h0;
                    phase_next = 1'b0;
                    if (lock_reg && (REQ.op == `FWES_OP_PROGRAM ||
                                     REQ.op == `FWES_OP_ERASE)) begin
                        refused_next = 1'b1;
                        done_next = 1'b1;
                    end else if (REQ.op == `FWES_OP_READ && array_mode_reg) begin
                        state_next = FWES_READ;
                    end else if (REQ.op == `FWES_OP_READ) begin
                        state_next = FWES_WR_ARRAY;
                    end else begin
                        state_next = FWES_WR_SETUP;
                    end
                end
            end
            FWES_WR_SETUP, FWES_WR_SECOND, FWES_WR_ARRAY: begin
                if (state_reg == FWES_WR_SECOND) begin
                    bus_next = wr_bus(req_reg.addr,
                        (req_reg.op == `FWES_OP_ERASE) ? {8'h00, `FWES_CMD_CONFIRM}
                                                       : req_reg.data, ~phase_reg);
                end else if (state_reg == FWES_WR_ARRAY) begin
                    bus_next = wr_bus(req_reg.addr, {8'h00, `FWES_CMD_READ_ARRAY}, ~phase_reg);
                end else begin
                    bus_next = wr_bus(req_reg.addr, {8'h00, first_code(req_reg.op)}, ~phase_reg);
                end
                cnt_next = cnt_reg + 2'h1;
                if (!phase_reg && cnt_reg == 2'(`FWES_TWP_CYC - 1)) begin
                    phase_next = 1'b1;
                    cnt_next = 2'h0;
                end else if (phase_reg && cnt_reg == 2'(`FWES_TWPH_CYC - 1)) begin
                    phase_next = 1'b0;
                    cnt_next = 2'h0;
                    if (state_reg == FWES_WR_ARRAY) begin
                        array_mode_next = 1'b1;
                        state_next = FWES_READ;
                    end else if (state_reg == FWES_WR_SECOND) begin
                        state_next = FWES_POLL;
                    end else begin
                        case (req_reg.op)
                            `FWES_OP_PROGRAM, `FWES_OP_ERASE: state_next = FWES_WR_SECOND;
                            `FWES_OP_SUSPEND, `FWES_OP_RESUME: state_next = FWES_POLL;
                            `FWES_OP_CLEAR: begin
                                status_next[`FWES_BIT_ERASE:`FWES_BIT_VPP] = 3'h0;
                                lock_next = 1'b0;
                                array_mode_next = 1'b0;
                                state_next = FWES_DONE;
                            end
                            default: begin
                                array_mode_next = 1'b1;
                                state_next = FWES_READ;
                            end
                        endcase
                    end
                end
            end
            FWES_POLL: begin
                array_mode_next = 1'b0;
                bus_next = '{ce_n: 1'b0, we_n: 1'b1, oe_n: 1'b0, dq_oe: 1'b0,
                             addr: req_reg.addr, dq_out: bus_reg.dq_out};
                cnt_next = cnt_reg + 2'h1;
                if (cnt_reg == 2'(`FWES_TRC_CYC + 1)) begin
                    cnt_next = 2'h0;
                    state_next = FWES_CHECK;
                end
            end
            FWES_CHECK: begin
                status_next = dq_s2_reg[7:0];
                if (dq_s2_reg[`FWES_BIT_READY]) begin
                    if (dq_s2_reg[`FWES_BIT_VPP]) begin
                        lock_next = 1'b1;
                    end
                    state_next = FWES_DONE;
                end else if (REQ_VALID && suspend_ok) begin
                    req_next = REQ;
                    state_next = FWES_WR_SETUP;
                end else begin
                    state_next = FWES_POLL;
                end
            end
            FWES_READ: begin
                bus_next = '{ce_n: 1'b0, we_n: 1'b1, oe_n: 1'b0, dq_oe: 1'b0,
                             addr: req_reg.addr, dq_out: bus_reg.dq_out};
                cnt_next = cnt_reg + 2'h1;
                if (cnt_reg == 2'(`FWES_TRC_CYC + 1)) begin
                    cnt_next = 2'h0;
                    rdata_next = dq_s2_reg;
                    state_next = FWES_DONE;
                end
            end
            FWES_DONE: begin
                done_next = 1'b1;
                state_next = FWES_IDLE;
            end
            default: state_next = FWES_IDLE;
        endcase
    end

    // state registers
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_reg <= FWES_IDLE;
            req_reg <= '0;
            cnt_reg <= 2'h0;
            phase_reg <= 1'b0;
            lock_reg <= 1'b0;
            done_reg <= 1'b0;
            refused_reg <= 1'b0;
            status_reg <= 8'h80;
            rdata_reg <= 16'h0000;
            array_mode_reg <= 1'b1;
            bus_reg <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, dq_oe: 1'b0,
                         addr: '0, dq_out: 16'h0000};
        end else begin
            state_reg <= state_next;
            req_reg <= req_next;
            cnt_reg <= cnt_next;
            phase_reg <= phase_next;
            lock_reg <= lock_next;
            done_reg <= done_next;
            refused_reg <= refused_next;
            status_reg <= status_next;
            rdata_reg <= rdata_next;
            array_mode_reg <= array_mode_next;
            bus_reg <= bus_next;
        end
    end

    assign DONE = done_reg;
    assign REFUSED = refused_reg;
    assign STATUS = status_reg;
    assign RDATA = rdata_reg;
    assign VPP_LOCK = lock_reg;
    assign BUS = bus_reg;

    sequence s_confirm_write;
        state_reg == FWES_WR_SECOND && req_reg.op == `FWES_OP_ERASE && !bus_reg.we_n;
    endsequence

    property p_lock_refuses_program;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        (state_reg == FWES_IDLE && REQ_VALID && lock_reg && REQ.op == `FWES_OP_PROGRAM)
        |=> refused_reg && state_reg == FWES_IDLE;
    endproperty
    a_lock_refuses_program: assert property (p_lock_refuses_program)
        else $error("program started while voltage error locked");

    property p_lock_refuses_erase;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        (state_reg == FWES_IDLE && REQ_VALID && lock_reg && REQ.op == `FWES_OP_ERASE)
        |=> refused_reg && done_reg;
    endproperty
    a_lock_refuses_erase: assert property (p_lock_refuses_erase)
        else $error("erase started while voltage error locked");

    property p_confirm_code;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        s_confirm_write |-> bus_reg.dq_out[7:0] == `FWES_CMD_CONFIRM && bus_reg.dq_oe;
    endproperty
    a_confirm_code: assert property (p_confirm_code)
        else $error("erase confirm cycle lacks confirm code");

    property p_lock_sticky;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        lock_reg && !(state_reg != FWES_IDLE && req_reg.op == `FWES_OP_CLEAR) |=> lock_reg;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky)
        else $error("error lock dropped without clear command");

    property p_array_before_read;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        $rose(state_reg == FWES_READ) |-> $past(array_mode_reg) || $past(state_reg) != FWES_IDLE;
    endproperty
    a_array_before_read: assert property (p_array_before_read)
        else $error("array read without read-array command");

    property p_poll_after_confirm;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        $fell(state_reg == FWES_WR_SECOND) |-> state_reg == FWES_POLL ##1 !bus_reg.oe_n;
    endproperty
    a_poll_after_confirm: assert property (p_poll_after_confirm)
        else $error("no status poll after second cycle");

    property p_done_ready;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        done_reg && !refused_reg |-> state_reg == FWES_IDLE ##1 REQ_READY || !REQ_VALID [*1];
    endproperty
    a_done_ready: assert property (p_done_ready)
        else $error("not ready for next operation after completion");

    property p_no_drive_on_read;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        !bus_reg.oe_n |-> !bus_reg.dq_oe && bus_reg.we_n;
    endproperty
    a_no_drive_on_read: assert property (p_no_drive_on_read)
        else $error("data driven during a read cycle");
endmodule
`default_nettype wire

// File: common/fwes_defines.svh
// timing and command constants for the flash write/erase host sequencer
`ifndef FWES_DEFINES_SVH
`define FWES_DEFINES_SVH
`define FWES_CLK_NS 50
`define FWES_CYC(ns) (((ns) + `FWES_CLK_NS - 1) / `FWES_CLK_NS)
`define FWES_TWP_NS 50
`define FWES_TWPH_NS 20
`define FWES_TRC_NS 90
`define FWES_TWP_CYC `FWES_CYC(`FWES_TWP_NS)
`define FWES_TWPH_CYC `FWES_CYC(`FWES_TWPH_NS)
`define FWES_TRC_CYC `FWES_CYC(`FWES_TRC_NS)
`define FWES_CMD_READ_ARRAY 8'hff
`define FWES_CMD_READ_STATUS 8'h70
`define FWES_CMD_CLEAR_STATUS 8'h50
`define FWES_CMD_ERASE_SETUP 8'h20
`define FWES_CMD_CONFIRM 8'hd0
`define FWES_CMD_SUSPEND 8'hb0
`define FWES_CMD_PROG_SETUP 8'h40
`define FWES_BIT_VPP 3
`define FWES_BIT_PROG 4
`define FWES_BIT_ERASE 5
`define FWES_BIT_SUSP 6
`define FWES_BIT_READY 7
`define FWES_OP_PROGRAM 3'h0
`define FWES_OP_ERASE 3'h1
`define FWES_OP_SUSPEND 3'h2
`define FWES_OP_RESUME 3'h3
`define FWES_OP_CLEAR 3'h4
`define FWES_OP_READ 3'h5
`endif

// File: common/fwes_pkg.sv
// types for the flash write/erase host sequencer
package fwes_pkg;
    typedef logic [18:0] fwes_addr_t;
    typedef logic [15:0] fwes_data_t;
    typedef struct packed {
        logic [2:0] op;
        fwes_addr_t addr;
        fwes_data_t data;
    } fwes_req_s;
    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic dq_oe;
        fwes_addr_t addr;
        fwes_data_t dq_out;
    } fwes_bus_s;
    typedef enum logic [3:0] {
        FWES_IDLE = 4'h0,
        FWES_WR_SETUP = 4'h1,
        FWES_WR_SECOND = 4'h2,
        FWES_POLL = 4'h3,
        FWES_CHECK = 4'h4,
        FWES_WR_ARRAY = 4'h5,
        FWES_READ = 4'h6,
        FWES_DONE = 4'h7
    } fwes_state_e;
endpackage

// File: testbench/fwes_flash_model.sv
// behavioural boot-block flash device answering the host sequencer's pins
`timescale 1ns/10ps
`default_nettype none
module fwes_flash_model (
    input wire logic clk,
    input wire logic rst,
    input wire fwes_pkg::fwes_bus_s bus,
    input wire logic [15:0] dq,
    input wire logic vpp_bad,
    input wire logic [7:0] busy_len,
    output logic [15:0] dq_drv,
    output logic busy,
    output var int n_prog,
    output var int n_erase
);
    import fwes_pkg::*;
    logic [15:0] mem [fwes_addr_t];
    logic [7:0] sr;
    logic [7:0] cnt;
    logic [1:0] pend;
    logic stat_mode, susp, we_q, ce_q;
    wire logic rd = !bus.ce_n && !bus.oe_n;
    assign busy = cnt != 8'h00;

    // status shows while busy and not suspended or in status mode, else the array word
    function automatic logic [15:0] rd_val();
        if (stat_mode || (busy && !susp))
            return {8'h00, sr};
        return mem.exists(bus.addr) ? mem[bus.addr] : 16'hffff;
    endfunction

    // one written command, acted on at the rising write strobe
    task automatic cmd(input logic [15:0] d);
        if (pend != 2'd0) begin
            pend <= 2'd0;
            if (pend == 2'd1 && d[7:0] != 8'hd0) begin
                sr[5:4] <= 2'b11;
            end else if (vpp_bad) begin
                sr[3] <= 1'b1;
                sr[pend == 2'd1 ? 5 : 4] <= 1'b1;
            end else if (!sr[3]) begin
                cnt <= busy_len;
                sr[7] <= 1'b0;
                if (pend == 2'd1) begin
                    n_erase <= n_erase + 1;
                    foreach (mem[a]) if (a[18:12] == bus.addr[18:12]) mem[a] = 16'hffff;
                end else begin
                    n_prog <= n_prog + 1;
                    mem[bus.addr] = (mem.exists(bus.addr) ? mem[bus.addr] : 16'hffff) & d;
                end
            end
        end else if (busy && !susp) begin
            if (d[7:0] == 8'hb0) begin
                susp <= 1'b1;
                sr[7:6] <= 2'b11;
            end
        end else if (susp && d[7:0] == 8'hd0) begin
            susp <= 1'b0;
            sr[7:6] <= 2'b00;
            stat_mode <= 1'b1;
        end else begin
            case (d[7:0])
                8'hff: stat_mode <= 1'b0;
                8'h70: stat_mode <= 1'b1;
                8'h50: if (!susp) sr[5:3] <= 3'b000;
                8'h20, 8'h40: if (!susp) begin
                    pend <= d[6] ? 2'd2 : 2'd1;
                    stat_mode <= 1'b1;
                end
                default: ;
            endcase
        end
    endtask

    // mid-cycle sampling of the strobes; released data lines toggle every cycle
    always @(negedge clk or posedge rst) begin
        if (rst) begin
            sr <= 8'h80;
            cnt <= 8'h00;
            pend <= 2'd0;
            stat_mode <= 1'b0;
            susp <= 1'b0;
            we_q <= 1'b1;
            ce_q <= 1'b1;
            n_prog <= 0;
            n_erase <= 0;
            dq_drv <= 16'h0000;
            mem.delete();
        end else begin
            we_q <= bus.we_n;
            ce_q <= bus.ce_n;
            dq_drv <= rd ? rd_val() : ~dq_drv;
            if (busy && !susp) begin
                cnt <= cnt - 8'h01;
                sr[7] <= cnt == 8'h01;
            end
            if (!we_q && bus.we_n && !ce_q)
                cmd(dq);
        end
    end
endmodule
`default_nettype wire

// File: testbench/fwes_host_tb_top.sv
// self-checking bench for the flash write/erase host sequencer
`timescale 1ns/10ps
`default_nettype none
module fwes_host_tb_top;
    import fwes_pkg::*;
    logic sys_clk, sys_rst, req_valid, req_ready, done, refused, vpp_lock, vpp_bad, busy, refd;
    logic [7:0] status, busy_len;
    logic [15:0] rdata, dq_drv, dq;
    fwes_req_s req;
    fwes_bus_s bus;
    int n_errors, tests_run, cycles, n_prog, n_erase, bp, be;
    assign dq = bus.dq_oe ? bus.dq_out : dq_drv;

    fwes_host fwes_host_inst (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .REQ_VALID(req_valid),
        .REQ_READY(req_ready), .REQ(req), .DONE(done), .REFUSED(refused), .STATUS(status),
        .RDATA(rdata), .VPP_LOCK(vpp_lock), .BUS(bus), .DQ_IN(dq));
    fwes_flash_model fwes_flash_model_inst (.clk(sys_clk), .rst(sys_rst), .bus(bus), .dq(dq),
        .vpp_bad(vpp_bad), .busy_len(busy_len), .dq_drv(dq_drv), .busy(busy),
        .n_prog(n_prog), .n_erase(n_erase));

    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // one request held until taken, then, unless wt is low, wait for its completion pulse
    task automatic op(input logic [2:0] o, input fwes_addr_t a, input fwes_data_t d,
                      input bit wt = 1'b1);
        int i;
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req <= {o, a, d};
        do @(negedge sys_clk); while (req_ready !== 1'b1);
        @(posedge sys_clk);
        req_valid <= 1'b0;
        if (wt) begin
            for (i = 0; i < 2000 && done !== 1'b1; i++) @(negedge sys_clk);
            refd = refused;
            check(done, 1'b1);
        end
    endtask

    task automatic t_prog();
        op(3'h0, 19'h01000, 16'h1234);
        check(busy, 1'b0);
        op(3'h0, 19'h01001, 16'h5678);
        check(n_prog[15:0], 16'd2);
        op(3'h5, 19'h01000, 16'h0000);
        check(rdata, 16'h1234);
        op(3'h5, 19'h01001, 16'h0000);
        check(rdata, 16'h5678);
    endtask

    task automatic t_erase();
        busy_len <= 8'd20;
        op(3'h1, 19'h01005, 16'h0000);
        check(busy, 1'b0);
        check(status, 8'h80);
        op(3'h1, 19'h02000, 16'h0000);
        check(n_erase[15:0], 16'd2);
        op(3'h5, 19'h01000, 16'h0000);
        check(rdata, 16'hffff);
        op(3'h1, 19'h03000, 16'h0000, 1'b0);
        op(3'h2, 19'h00000, 16'h0000);
        check(status, 8'hc0);
        op(3'h5, 19'h01000, 16'h0000);
        check(rdata, 16'hffff);
        op(3'h3, 19'h00000, 16'h0000);
        check(status, 8'h80);
        check(n_erase[15:0], 16'd3);
    endtask

    task automatic t_vpp();
        busy_len <= 8'd5;
        vpp_bad <= 1'b1;
        op(3'h0, 19'h04000, 16'h00ff);
        check(status[3], 1'b1);
        check(vpp_lock, 1'b1);
        vpp_bad <= 1'b0;
        bp = n_prog;
        be = n_erase;
        op(3'h0, 19'h04001, 16'h1111);
        check(refd, 1'b1);
        op(3'h1, 19'h04000, 16'h0000);
        check(refd, 1'b1);
        check(n_prog[15:0] - bp[15:0], 16'd0);
        check(n_erase[15:0] - be[15:0], 16'd0);
        check(status[3], 1'b1);
        op(3'h4, 19'h00000, 16'h0000);
        check(vpp_lock, 1'b0);
        check(status & 8'h38, 8'h00);
        op(3'h0, 19'h04001, 16'h1111);
        check(refd, 1'b0);
        check(n_prog[15:0] - bp[15:0], 16'd1);
        op(3'h5, 19'h04001, 16'h0000);
        check(rdata, 16'h1111);
    endtask

    // counts, verdict and end of run
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // free-running clock at 50 ns
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            end_of_test();
        end
    end

    // reset, idle checks, then the scenarios
    initial begin
        sys_rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        vpp_bad = 1'b0;
        busy_len = 8'd5;
        cycles = 0;
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(negedge sys_clk);
        check(status, 8'h80);
        check({bus.ce_n, bus.we_n, bus.oe_n, bus.dq_oe, vpp_lock, req_ready}, 6'h39);
        t_prog();
        t_erase();
        t_vpp();
        end_of_test();
    end
endmodule
`default_nettype wire
